// ==== logic/apk_pkg.sv ====
// ----------------------------------------
// Shared constants and types
// ----------------------------------------
package apk_pkg;

	// Status nibble values carried in F[35:32].
	localparam logic [3:0] FIELD_START_CODE = 4'h6;
	localparam logic [3:0] LINE_START_CODE = 4'h1;
	localparam logic [3:0] VALID_SAMPLE_CODE = 4'h0;
	localparam logic [3:0] LINE_END_CODE_BASE = 4'h8;
	localparam logic [3:0] FIELD_END_CODE = 4'hC;

	// Register byte offsets on the Avalon slave.
	localparam logic [3:0] REG_CTRL_OFS = 4'h0;
	localparam logic [3:0] REG_LEN_OFS = 4'h4;
	localparam logic [3:0] REG_STAT_OFS = 4'h8;

	// Field positions inside the length and status words.
	localparam int LEN_LINE_LSB = 0;
	localparam int LEN_FIELD_LSB = 16;
	localparam int STAT_LINES_LSB = 4;

	// Values after reset.
	localparam logic [12:0] CTRL_RST = 13'h0000;
	localparam logic [11:0] LINE_BYTES_RST = 12'h010;
	localparam logic [7:0] FIELD_LINES_RST = 8'h04;

	// Byte counts of the three unit sizes a source delivers.
	localparam logic [2:0] UNIT_BYTE = 3'h1;
	localparam logic [2:0] UNIT_WORD = 3'h2;
	localparam logic [2:0] UNIT_DWORD = 3'h4;

	// Control register layout; bit 0 is the capture enable.
	typedef struct packed {
		logic [4:0] sync_bit_delay;
		logic bit_order_select;
		logic channel_edge_select;
		logic sample_edge_select;
		logic packet_mode_select;
		logic sample_size_select;
		logic source_select;
		logic buffer_enable;
		logic capture_enable_bit;
	} apk_ctrl_s;

	// One 36-bit FIFO word.
	typedef struct packed {
		logic [3:0] status;
		logic [31:0] data;
	} apk_fifo_word_s;

	// A group of bytes handed from a source to the packer.
	typedef struct packed {
		logic [2:0] nbytes;
		logic frame_first;
		logic [31:0] data;
	} apk_unit_s;

	// Capture sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FSTART = 2'b01,
		ST_LINE = 2'b10,
		ST_FEND = 2'b11
	} apk_state_e;

	// Line-end code for a last word holding n valid bytes (n = 1..4).
	function automatic logic [3:0] apk_end_code(input logic [2:0] n);
		apk_end_code = LINE_END_CODE_BASE + {1'b0, n} - 4'h1;
	endfunction : apk_end_code

endpackage : apk_pkg

// ==== logic/apk_pin_sync.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Serial pin synchroniser and edge finder
// ----------------------------------------
module apk_pin_sync
	import apk_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sclk_pin,
	input wire logic ws_pin,
	input wire logic dat_pin,
	input wire logic edge_sel,
	output logic smp_stb,
	output logic ws_smp,
	output logic dat_smp
);

	// First and second stages; the first is read only by the second.
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	// Previous bit clock level for edge finding.
	logic sclk_prev_q;
	logic sclk_edge;

	// The three pins pass two flops, so all see the same delay.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			sclk_prev_q <= 1'b0;
		end else begin
			s1_q <= {sclk_pin, ws_pin, dat_pin}; // R23
			s2_q <= s1_q; // R23
			sclk_prev_q <= s2_q[2];
		end
	end

	// Pick the rising or falling bit clock edge.
	assign sclk_edge = edge_sel ? (sclk_prev_q & ~s2_q[2]) : (~sclk_prev_q & s2_q[2]); // R14

	// Word sync and data are caught on the chosen edge.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			smp_stb <= 1'b0;
			ws_smp <= 1'b0;
			dat_smp <= 1'b0;
		end else begin
			smp_stb <= sclk_edge; // R12
			if (sclk_edge) begin
				ws_smp <= s2_q[1];
				dat_smp <= s2_q[0];
			end
		end
	end

	property p_edge_pick;
		@(posedge mclk) disable iff (sys_rst)
		(~sclk_prev_q & s2_q[2] & ~edge_sel) |=> smp_stb;
	endproperty
	a_edge_pick: assert property (p_edge_pick) else $error("rising edge missed"); // R14

endmodule : apk_pin_sync

// ==== logic/apk_packetizer.sv ====
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Function
// R01 - Capture starts with a field-start word.
// R02 - Line: start word, valid words, end word.
// R03 - Lines DWORD aligned; end code counts bytes.
// R04 - Line byte length alone places line ends.
// R05 - Software picks length granularity per mode.
// R06 - Samples packed little-endian, status on top.
// R07 - Length mod 4 of 2 ends line early.
// R08 - Stereo pair per DWORD; packet bytes continue.
// R09 - Field-end word after the programmed lines.
// R10 - Fields repeat; stop only after field end.
// R11 - Buffer disable stops writes, resets sequencer.
// R12 - System clock oversamples serial bit clock.
// R13 - Source keeps stereo bit clock slow enough.
// R14 - Edge select picks sampling bit clock edge.
// R15 - Channel select names rising-sync channel; left first.
// R16 - Delay counts bit clocks to first bit.
// R17 - Bit order select: MSB or LSB first.
// R18 - Extra or paused bit clocks are tolerated.
// R19 - Source sends packet bytes back to back.
// R20 - Packet bytes start after delay, every eight.
// R21 - Collect exactly line length bytes per frame.
// R22 - Packet capture waits for a frame start.
// R23 - Serial pins pass two flops first.
module apk_packetizer
	import apk_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serial_bit_clock_in,
	input wire logic word_sync_in,
	input wire logic serial_audio_in,
	input wire logic conv_valid,
	input wire logic [15:0] conv_sample,
	output logic fifo_wr,
	output apk_fifo_word_s fifo_word
);

	// ----------------------------------------
	// Registers and bus slave
	// ----------------------------------------

	// Control bits steering the whole block.
	apk_ctrl_s ctrl_q;
	// Programmed line length in bytes.
	logic [11:0] line_bytes_q;
	// Programmed lines per field.
	logic [7:0] field_lines_q;
	// Bus answer flops.
	logic wait_q;
	logic [31:0] rdata_q;
	// Sequencer state shown in the status word.
	apk_state_e st_q;
	logic [7:0] lines_q;
	logic pend_q;

	// Every access waits exactly one cycle, then completes.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_q <= 1'b1;
		end else if (!wait_q) begin
			wait_q <= 1'b1;
		end else if (avs_read || avs_write) begin
			wait_q <= 1'b0;
		end
	end

	// Read data is built while waitrequest is still high.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 32'h0;
		end else if (avs_read && wait_q) begin
			case (avs_address)
				REG_CTRL_OFS: rdata_q <= {19'h0, ctrl_q};
				REG_LEN_OFS: rdata_q <= {8'h0, field_lines_q, 4'h0, line_bytes_q};
				REG_STAT_OFS: rdata_q <= {20'h0, lines_q, 1'b0, pend_q, st_q};
				default: rdata_q <= 32'h0;
			endcase
		end
	end

	// Writes land on the edge where waitrequest is low.
	// Unmapped offsets and the status word ignore writes.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RST;
			line_bytes_q <= LINE_BYTES_RST;
			field_lines_q <= FIELD_LINES_RST;
		end else if (avs_write && !wait_q) begin
			if (avs_address == REG_CTRL_OFS) begin
				ctrl_q <= avs_writedata[12:0];
			end else if (avs_address == REG_LEN_OFS) begin
				line_bytes_q <= avs_writedata[LEN_LINE_LSB +: 12];
				field_lines_q <= avs_writedata[LEN_FIELD_LSB +: 8];
			end
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

	// ----------------------------------------
	// Serial receiver
	// ----------------------------------------

	// Synchronised samples taken on the chosen bit clock edge.
	logic smp_stb;
	logic ws_smp;
	logic dat_smp;

	apk_pin_sync u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.sclk_pin(serial_bit_clock_in),
		.ws_pin(word_sync_in),
		.dat_pin(serial_audio_in),
		.edge_sel(ctrl_q.sample_edge_select),
		.smp_stb(smp_stb),
		.ws_smp(ws_smp),
		.dat_smp(dat_smp)
	);

	// Word sync level at the previous sample.
	logic ws_prev_q;
	// Collection window open since the last sync.
	logic active_q;
	// Bit clocks still to skip before the first bit.
	logic [4:0] dly_q;
	// Bits collected into the current word or byte.
	logic [3:0] nb_q;
	// Serial shift register.
	logic [15:0] sh_q;
	// Bytes taken from the current packet frame.
	logic [11:0] pbytes_q;
	// Current stereo word is the right channel.
	logic is_right_q;
	// Held left sample waiting for its partner.
	logic [15:0] left_q;
	logic have_left_q;
	// Unit handed to the packer, one-cycle valid.
	apk_unit_s unit_q;
	logic unit_v_q;

	logic ws_rise;
	logic ws_fall;
	logic sync_edge;
	logic [4:0] cur_dly;
	logic [3:0] nb_cur;
	logic [11:0] pb_cur;
	logic take_bit;
	logic [15:0] sh_d;
	logic word_done;
	logic byte_done;
	logic [7:0] byte_d;

	assign ws_rise = smp_stb & ws_smp & ~ws_prev_q;
	assign ws_fall = smp_stb & ~ws_smp & ws_prev_q;
	// Stereo syncs on both word-sync edges; packet mode on one.
	assign sync_edge = ctrl_q.packet_mode_select ? (ctrl_q.channel_edge_select ? ws_fall : ws_rise) // R20
		: (ws_rise | ws_fall);
	assign cur_dly = sync_edge ? ctrl_q.sync_bit_delay : dly_q; // R16
	assign nb_cur = sync_edge ? 4'h0 : nb_q;
	assign pb_cur = sync_edge ? 12'h0 : pbytes_q;
	// Clocks outside the window are ignored, so any count works.
	assign take_bit = smp_stb & (sync_edge | active_q) & (cur_dly == 5'h0); // R18
	assign sh_d = ctrl_q.bit_order_select ? {dat_smp, sh_q[15:1]} : {sh_q[14:0], dat_smp}; // R17
	assign word_done = take_bit & ~ctrl_q.packet_mode_select & (nb_cur == 4'hF);
	assign byte_done = take_bit & ctrl_q.packet_mode_select & (nb_cur[2:0] == 3'h7); // R20
	// An LSB-first byte sits in the top of the right-shifting register.
	assign byte_d = ctrl_q.bit_order_select ? sh_d[15:8] : sh_d[7:0]; // R17

	// Window, delay and bit counting per sync.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ws_prev_q <= 1'b0;
			active_q <= 1'b0;
			dly_q <= 5'h0;
			nb_q <= 4'h0;
			sh_q <= 16'h0;
			pbytes_q <= 12'h0;
			is_right_q <= 1'b0;
		end else begin
			if (smp_stb) begin
				ws_prev_q <= ws_smp;
			end
			if (sync_edge) begin
				active_q <= 1'b1;
				pbytes_q <= 12'h0;
				is_right_q <= ws_rise ? ctrl_q.channel_edge_select : ~ctrl_q.channel_edge_select; // R15
			end
			if (smp_stb && (sync_edge || active_q)) begin
				dly_q <= (cur_dly != 5'h0) ? cur_dly - 5'h1 : 5'h0; // R16
			end
			if (take_bit) begin
				sh_q <= sh_d;
				nb_q <= nb_cur + 4'h1;
			end else if (sync_edge) begin
				nb_q <= 4'h0;
			end
			// Sixteen bits close a stereo word; later clocks wait.
			if (word_done) begin
				active_q <= 1'b0; // R18
			end
			// A frame closes after the line length in bytes.
			if (byte_done) begin
				pbytes_q <= pb_cur + 12'h1;
				if (pb_cur + 12'h1 >= line_bytes_q) begin
					active_q <= 1'b0; // R21
				end
			end
		end
	end

	// Units from the converter input or the serial receiver.
	// Converter samples must be at least two cycles apart.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			unit_q <= '0;
			unit_v_q <= 1'b0;
			left_q <= 16'h0;
			have_left_q <= 1'b0;
		end else begin
			unit_v_q <= 1'b0;
			if (!ctrl_q.source_select) begin
				if (conv_valid) begin
					unit_v_q <= 1'b1;
					unit_q.frame_first <= 1'b0;
					if (ctrl_q.sample_size_select) begin
						unit_q.nbytes <= UNIT_BYTE; // R06
						unit_q.data <= {24'h0, conv_sample[7:0]};
					end else begin
						unit_q.nbytes <= UNIT_WORD; // R06
						unit_q.data <= {16'h0, conv_sample};
					end
				end
			end else if (word_done) begin
				// A right word with no left before it is dropped.
				if (!is_right_q) begin
					left_q <= sh_d;
					have_left_q <= 1'b1;
				end else if (have_left_q) begin
					unit_v_q <= 1'b1;
					unit_q <= {UNIT_DWORD, 1'b0, sh_d, left_q}; // R08 R15
					have_left_q <= 1'b0;
				end
			end else if (byte_done) begin
				unit_v_q <= 1'b1;
				unit_q <= {UNIT_BYTE, pb_cur == 12'h0, 24'h0, byte_d};
			end
		end
	end

	// ----------------------------------------
	// Line and field packer
	// ----------------------------------------

	// Partly filled DWORD and its fill position.
	logic [31:0] acc_q;
	logic [1:0] pos_q;
	// Bytes still owed to the current line.
	logic [11:0] line_left_q;
	// Next word written is the first of its line.
	logic first_q;
	// Packet mode still waits for a frame start.
	logic wait_frame_q;
	// Single pending word between packer and FIFO port.
	apk_fifo_word_s pend_word_q;

	logic accept;
	logic [2:0] tk;
	logic [2:0] newpos;
	logic [31:0] placed;
	logic [31:0] mask;
	logic last;
	logic emit;
	logic [3:0] code;

	// A unit is taken only in a line with the slot free.
	assign accept = unit_v_q & (st_q == ST_LINE) & ~pend_q & ~(wait_frame_q & ~unit_q.frame_first); // R22
	// Bytes past the line end are cut off, never carried.
	assign tk = (line_left_q < {9'h0, unit_q.nbytes}) ? line_left_q[2:0] : unit_q.nbytes; // R04
	assign newpos = {1'b0, pos_q} + tk;
	assign last = (line_left_q == {9'h0, tk}); // R04 R07
	assign emit = last | (newpos == UNIT_DWORD);

	// Earliest bytes go to the lowest lanes.
	always_comb begin
		case (tk)
			3'h1: mask = 32'h0000_00FF;
			3'h2: mask = 32'h0000_FFFF;
			// A stereo pair cut by a short line keeps its three low bytes.
			3'h3: mask = 32'h00FF_FFFF; // R04
			3'h4: mask = 32'hFFFF_FFFF;
			default: mask = 32'h0;
		endcase
		placed = acc_q | ((unit_q.data & mask) << {pos_q, 3'h0}); // R06
		if (last) begin
			code = apk_end_code(newpos); // R03
		end else if (first_q) begin
			code = LINE_START_CODE; // R02
		end else begin
			code = VALID_SAMPLE_CODE; // R02
		end
	end

	// Sequencer, packer and FIFO write port share one process
	// so the pending slot has a single owner.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			acc_q <= 32'h0;
			pos_q <= 2'h0;
			line_left_q <= 12'h0;
			first_q <= 1'b1;
			lines_q <= 8'h0;
			wait_frame_q <= 1'b0;
			pend_q <= 1'b0;
			pend_word_q <= '0;
			fifo_wr <= 1'b0;
			fifo_word <= '0;
		end else if (!ctrl_q.buffer_enable) begin
			// Disabling the buffer drops everything at once.
			st_q <= ST_IDLE; // R11
			pend_q <= 1'b0; // R11
			fifo_wr <= 1'b0; // R11
			acc_q <= 32'h0;
			pos_q <= 2'h0;
		end else begin
			// A write is always followed by a dead cycle.
			fifo_wr <= 1'b0;
			if (pend_q && !fifo_wr) begin
				fifo_wr <= 1'b1;
				fifo_word <= pend_word_q;
				pend_q <= 1'b0;
			end
			case (st_q)
				ST_IDLE: begin
					if (ctrl_q.capture_enable_bit) begin
						st_q <= ST_FSTART;
					end
				end
				ST_FSTART: begin
					if (!pend_q) begin
						pend_q <= 1'b1;
						pend_word_q <= {FIELD_START_CODE, 32'h0}; // R01
						st_q <= ST_LINE;
						lines_q <= 8'h0;
						line_left_q <= line_bytes_q;
						first_q <= 1'b1;
						acc_q <= 32'h0;
						pos_q <= 2'h0;
						wait_frame_q <= ctrl_q.packet_mode_select & ctrl_q.source_select; // R22
					end
				end
				ST_LINE: begin
					if (accept) begin
						wait_frame_q <= 1'b0;
						line_left_q <= line_left_q - {9'h0, tk};
						if (emit) begin
							pend_q <= 1'b1;
							pend_word_q <= {code, placed};
							acc_q <= 32'h0;
							pos_q <= 2'h0;
							first_q <= 1'b0;
						end else begin
							acc_q <= placed;
							pos_q <= newpos[1:0];
						end
						if (last) begin
							// Next line starts aligned in lane zero.
							line_left_q <= line_bytes_q; // R03
							first_q <= 1'b1;
							lines_q <= lines_q + 8'h1;
							if (lines_q + 8'h1 == field_lines_q) begin
								st_q <= ST_FEND; // R09
							end
						end
					end
				end
				ST_FEND: begin
					if (!pend_q) begin
						pend_q <= 1'b1;
						pend_word_q <= {FIELD_END_CODE, 32'h0}; // R09
						st_q <= ctrl_q.capture_enable_bit ? ST_FSTART : ST_IDLE; // R10
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	property p_fstart;
		@(posedge mclk) disable iff (sys_rst)
		(st_q == ST_FSTART && !pend_q && ctrl_q.buffer_enable)
		|-> ##[1:2] (fifo_wr && fifo_word.status == FIELD_START_CODE);
	endproperty
	a_fstart: assert property (p_fstart) else $error("no field start word"); // R01

	property p_fend;
		@(posedge mclk) disable iff (sys_rst)
		(st_q == ST_LINE && accept && last && lines_q + 8'h1 == field_lines_q && ctrl_q.buffer_enable)
		##1 ctrl_q.buffer_enable [*3] |=> (fifo_wr && fifo_word.status == FIELD_END_CODE);
	endproperty
	a_fend: assert property (p_fend) else $error("field end not written"); // R09

	property p_dead_cycle;
		@(posedge mclk) disable iff (sys_rst)
		fifo_wr |=> !fifo_wr;
	endproperty
	a_dead_cycle: assert property (p_dead_cycle) else $error("back to back writes"); // R02

	property p_disable;
		@(posedge mclk) disable iff (sys_rst)
		!ctrl_q.buffer_enable |=> (!fifo_wr && st_q == ST_IDLE && !pend_q);
	endproperty
	a_disable: assert property (p_disable) else $error("writes after buffer disable"); // R11

	property p_repeat;
		@(posedge mclk) disable iff (sys_rst)
		(st_q == ST_FEND && !pend_q && ctrl_q.buffer_enable && ctrl_q.capture_enable_bit)
		|=> st_q == ST_FSTART;
	endproperty
	a_repeat: assert property (p_repeat) else $error("field did not repeat"); // R10

	property p_delay;
		@(posedge mclk) disable iff (sys_rst)
		(sync_edge && ctrl_q.sync_bit_delay != 5'h0) |-> !take_bit ##1 (dly_q == $past(ctrl_q.sync_bit_delay) - 5'h1);
	endproperty
	a_delay: assert property (p_delay) else $error("bit taken inside delay"); // R16

	property p_lsb_first;
		@(posedge mclk) disable iff (sys_rst)
		(take_bit && ctrl_q.bit_order_select) |=> sh_q[15] == $past(dat_smp);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong"); // R17

	property p_frame_len;
		@(posedge mclk) disable iff (sys_rst)
		(byte_done && !sync_edge && pb_cur + 12'h1 >= line_bytes_q) |=> !active_q;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not closed"); // R21

	property p_pair;
		@(posedge mclk) disable iff (sys_rst)
		(ctrl_q.source_select && word_done && is_right_q && have_left_q)
		|=> (unit_v_q && unit_q.data[15:0] == $past(left_q) && unit_q.nbytes == UNIT_DWORD);
	endproperty
	a_pair: assert property (p_pair) else $error("stereo pair misplaced"); // R15

	c_field_end: cover property (@(posedge mclk) fifo_wr && fifo_word.status == FIELD_END_CODE);
	c_short_end: cover property (@(posedge mclk) fifo_wr && fifo_word.status == apk_end_code(UNIT_WORD));
	c_stereo: cover property (@(posedge mclk) unit_v_q && unit_q.nbytes == UNIT_DWORD);

endmodule : apk_packetizer

// ==== tb/apk_serial_src.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Serial source on the far side of the three-wire link
// ----------------------------------------
module apk_serial_src (
	output logic sclk,
	output logic ws,
	output logic dat
);
	// Link lines start quiet.
	initial begin
		sclk = 1'b0;
		ws = 1'b0;
		dat = 1'b0;
	end

	// Sends one frame, bit 0 of the vector first, with no gaps between bits.
	// The clock rests at its idle level outside frames; hp sets its speed.
	task automatic frame(input logic ws_lvl, input int nbits, input logic [63:0] bits, input logic fe,
		input int hp);
		sclk = fe;
		#hp;
		ws = ws_lvl;
		for (int i = 0; i < nbits; i++) begin
			dat = bits[i];
			#hp;
			sclk = ~fe;
			#hp;
			sclk = fe;
		end
		// The data line is inverted after the last bit, so it does not keep showing it.
		dat = ~dat;
	endtask : frame
endmodule : apk_serial_src

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ----------------------------------------
// Packetizer testbench
// ----------------------------------------
module tb
	import apk_pkg::*;
();
	logic mclk = 1'b0; // System clock.
	logic sys_rst = 1'b1; // Reset, held high at start.
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sclk;
	logic ws;
	logic dat;
	logic conv_valid = 1'b0;
	logic [15:0] conv_sample = 16'h0;
	logic fifo_wr;
	apk_fifo_word_s fifo_word;
	int n_mismatch = 0;
	int cmp_count = 0;
	apk_fifo_word_s q[$]; // Words the block has written, oldest first.

	always #2 mclk = ~mclk;

	apk_packetizer dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_bit_clock_in(sclk), .word_sync_in(ws),
		.serial_audio_in(dat), .conv_valid(conv_valid), .conv_sample(conv_sample),
		.fifo_wr(fifo_wr), .fifo_word(fifo_word));

	apk_serial_src src (.sclk(sclk), .ws(ws), .dat(dat));

	// Collects every word written; the pulse stands one cycle only.
	always @(posedge mclk) begin
		if (fifo_wr === 1'b1) begin
			q.push_back(fifo_word);
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// One Avalon access; holds the request until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		rd = avs_readdata;
		if (n >= 100) n_mismatch++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wreg

	// Takes the next written word, waiting a bounded time, and compares it.
	task automatic pull(input logic [3:0] st, input logic [31:0] d, input logic [31:0] m);
		int n;
		apk_fifo_word_s w;
		n = 0;
		while (q.size() == 0 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		if (q.size() == 0) begin
			n_mismatch++;
			w = '0;
		end else begin
			w = q.pop_front();
		end
		`CHK(w.status, st);
		`CHK(w.data & m, d & m);
	endtask : pull

	// One converter sample; pulses are kept four cycles apart.
	task automatic conv(input logic [15:0] s);
		conv_sample <= s;
		conv_valid <= 1'b1;
		@(posedge mclk);
		conv_valid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : conv

	task automatic report_and_stop();
		$display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values, a read-only status word and an unmapped address.
	task automatic t_regs();
		logic [31:0] r;
		wreg(4'hC, 32'hFFFF_FFFF);
		wreg(REG_STAT_OFS, 32'hFFFF_FFFF);
		bus(1'b0, REG_CTRL_OFS, 32'h0, r);
		`CHK(r, 32'(CTRL_RST));
		bus(1'b0, REG_LEN_OFS, 32'h0, r);
		`CHK(r, (32'(FIELD_LINES_RST) << LEN_FIELD_LSB) | (32'(LINE_BYTES_RST) << LEN_LINE_LSB));
		bus(1'b0, REG_STAT_OFS, 32'h0, r);
		`CHK(r, 32'h0);
		bus(1'b0, 4'hC, 32'h0, r);
		`CHK(r, 32'h0);
	endtask : t_regs

	// Converter words, six-byte lines, two lines a field, then buffer disable.
	task automatic t_conv();
		wreg(REG_LEN_OFS, 32'h0002_0006);
		wreg(REG_CTRL_OFS, 32'h0000_0003);
		pull(FIELD_START_CODE, 32'h0, 32'h0);
		for (int i = 0; i < 6; i++) conv(16'hA500 + 16'(i));
		pull(LINE_START_CODE, 32'hA501_A500, 32'hFFFF_FFFF);
		pull(LINE_END_CODE_BASE + 4'h1, 32'h0000_A502, 32'h0000_FFFF);
		pull(LINE_START_CODE, 32'hA504_A503, 32'hFFFF_FFFF);
		pull(LINE_END_CODE_BASE + 4'h1, 32'h0000_A505, 32'h0000_FFFF);
		pull(FIELD_END_CODE, 32'h0, 32'h0);
		pull(FIELD_START_CODE, 32'h0, 32'h0);
		// Buffer off while capture stays on: nothing more may be written.
		wreg(REG_CTRL_OFS, 32'h0000_0001);
		conv(16'h1111);
		conv(16'h2222);
		repeat (50) @(posedge mclk);
		`CHK(q.size(), 0);
		wreg(REG_CTRL_OFS, 32'h0000_0003);
		pull(FIELD_START_CODE, 32'h0, 32'h0);
		wreg(REG_CTRL_OFS, 32'h0000_0000);
		repeat (20) @(posedge mclk);
		q.delete();
	endtask : t_conv

	// Byte-size converter samples, three-byte line: one short line-end word only.
	task automatic t_conv8();
		wreg(REG_LEN_OFS, 32'h0001_0003);
		wreg(REG_CTRL_OFS, 32'h0000_000B);
		pull(FIELD_START_CODE, 32'h0, 32'h0);
		conv(16'hEE11);
		conv(16'hEE22);
		conv(16'hEE33);
		pull(LINE_END_CODE_BASE + 4'h2, 32'h0033_2211, 32'h00FF_FFFF);
		pull(FIELD_END_CODE, 32'h0, 32'h0);
		pull(FIELD_START_CODE, 32'h0, 32'h0);
		wreg(REG_CTRL_OFS, 32'h0000_0000);
		repeat (20) @(posedge mclk);
		`CHK(q.size(), 0);
	endtask : t_conv8

	// Stereo pairs, LSB first, one-clock delay; capture cleared mid-field.
	task automatic t_stereo();
		wreg(REG_LEN_OFS, 32'h0001_0008);
		wreg(REG_CTRL_OFS, 32'h0000_0187);
		pull(FIELD_START_CODE, 32'h0, 32'h0);
		src.frame(1'b1, 20, 64'({16'h1234, 1'b0}), 1'b0, 170);
		src.frame(1'b0, 20, 64'({16'h5678, 1'b0}), 1'b0, 170);
		wreg(REG_CTRL_OFS, 32'h0000_0186);
		src.frame(1'b1, 20, 64'({16'h9ABC, 1'b0}), 1'b0, 170);
		src.frame(1'b0, 20, 64'({16'hDEF0, 1'b0}), 1'b0, 170);
		pull(LINE_START_CODE, 32'h5678_1234, 32'hFFFF_FFFF);
		pull(LINE_END_CODE_BASE + 4'h3, 32'hDEF0_9ABC, 32'hFFFF_FFFF);
		pull(FIELD_END_CODE, 32'h0, 32'h0);
		repeat (200) @(posedge mclk);
		`CHK(q.size(), 0);
		wreg(REG_CTRL_OFS, 32'h0000_0000);
	endtask : t_stereo

	// Byte packets, MSB first, falling edges; seven bytes into a five-byte line.
	task automatic t_packet();
		logic [63:0] v;
		logic [7:0] b;
		v = '0;
		for (int i = 0; i < 7; i++) begin
			b = 8'h31 + 8'(i);
			for (int j = 0; j < 8; j++) v[i * 8 + j] = b[7 - j];
		end
		wreg(REG_LEN_OFS, 32'h0001_0005);
		wreg(REG_CTRL_OFS, 32'h0000_0077);
		pull(FIELD_START_CODE, 32'h0, 32'h0);
		// Stray bits ahead of the framing edge must not be collected.
		src.frame(1'b1, 4, 64'hF, 1'b1, 80);
		src.frame(1'b0, 60, v, 1'b1, 80);
		pull(LINE_START_CODE, 32'h3433_3231, 32'hFFFF_FFFF);
		pull(LINE_END_CODE_BASE, 32'h0000_0035, 32'h0000_00FF);
		pull(FIELD_END_CODE, 32'h0, 32'h0);
		pull(FIELD_START_CODE, 32'h0, 32'h0);
		repeat (100) @(posedge mclk);
		`CHK(q.size(), 0);
		wreg(REG_CTRL_OFS, 32'h0000_0000);
	endtask : t_packet

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_conv();
		t_conv8();
		t_stereo();
		t_packet();
		report_and_stop();
	end

	// The tests need well under this span; reaching it means a hang.
	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : tb
